// ### src/wdol_pkg.sv
// package for the watchdog and its write-once option latches
// assumes one oscillator clock domain and a byte-wide internal cpu bus
package wdol_pkg;
   // ==================================================
   // bus addresses
   localparam logic [15:0] WDOL_ADDR_OPT_TWO = 16'h001E;
   localparam logic [15:0] WDOL_ADDR_OPT_ONE = 16'h001F;
   localparam logic [15:0] WDOL_ADDR_SERVICE = 16'hFFFF;
   localparam logic [15:0] WDOL_ADDR_VEC_HI = 16'hFFFE;
   // ==================================================
   // option register two fields
   localparam int WDOL_O2_TIMEBASE_SEL = 3;
   localparam int WDOL_O2_OSC_IN_STOP = 1;
   localparam int WDOL_O2_BAUD_SRC = 0;
   // option register one fields
   localparam int WDOL_O1_RATE_SEL = 7;
   localparam int WDOL_O1_DET_STOP_EN = 6;
   localparam int WDOL_O1_DET_RST_DIS = 5;
   localparam int WDOL_O1_DET_PWR_DIS = 4;
   localparam int WDOL_O1_DET_VMODE = 3;
   localparam int WDOL_O1_SHORT_REC = 2;
   localparam int WDOL_O1_STOP_EN = 1;
   localparam int WDOL_O1_WDOG_DIS = 0;
   // ==================================================
   // reset values
   localparam logic [7:0] WDOL_OPT_TWO_RST = 8'h00;
   localparam logic [7:0] WDOL_OPT_ONE_RST = 8'h00;
   // ==================================================
   // timing; widths in bits, the rest in oscillator clock cycles
   localparam int WDOL_PRE_BITS = 12;
   localparam int WDOL_CNT_BITS = 6;
   localparam int WDOL_PERIOD_FAST = 8176;
   localparam int WDOL_PERIOD_SLOW = 262128;
   localparam int WDOL_RST_PULSE = 32;
   localparam int WDOL_REC_SHORT = 32;
   localparam int WDOL_REC_LONG = 4096;
   localparam int WDOL_POR_CLEAR = 4096;
   localparam int WDOL_TB_DIV = 128;
   // ==================================================
   typedef struct packed {
      logic timebase_prescale_select;
      logic oscillator_in_stop_enable;
      logic serial_baud_clock_source;
      logic detector_stop_enable;
      logic detector_reset_disable;
      logic detector_power_disable;
      logic detector_voltage_mode;
      logic stop_instruction_enable;
   } wdol_opts_s;
   typedef enum logic [1:0] {
      WDOL_RUN = 2'b00,
      WDOL_STOP = 2'b01,
      WDOL_RECOVER = 2'b11
   } wdol_mode_e;
endpackage

// ### src/wdol_top.sv
// watchdog with write-once option latches, oscillator clock domain
// assumes bus strobes are single-cycle, synchronous to clock
//
// Contract
// RQ1: each option register takes only its first write after any reset
// RQ2: option registers at 001E and 001F always readable
// RQ3: voltage-mode bit cleared and re-armed only by power-on reset
// RQ4: timebase select 1 inserts a divide-by-128 prescaler, 0 bypasses it
// RQ5: oscillator-in-stop 1 keeps oscillator running in stop mode
// RQ6: baud source 1 selects bus clock, 0 selects oscillator clock
// RQ7: rate bit selects 8176 or 262128 cycle overflow period
// RQ8: detector stop enable keeps detector alive in stop unless powered down
// RQ9: reset-disable blocks detector reset; power-disable powers detector down
// RQ10: voltage-mode 1 selects 5-V trip mode, 0 the 3-V mode
// RQ11: stop recovery lasts 32 cycles if short bit set, else 4096
// RQ12: stop exit by detector reset always uses long recovery
// RQ13: stop enable 0 makes the stop instruction an illegal opcode
// RQ14: watchdog disable bit 1 stops the watchdog producing resets
// RQ15: 6-bit counter fed by 12-bit prescaler; overflow resets chip
// RQ16: any write to FFFF clears counter and prescaler stages 12 to 5
// RQ17: read of FFFF returns reset vector low byte, no watchdog effect
// RQ18: overflow drives reset pin low 32 cycles and sets status flag
// RQ19: stop instruction clears the prescaler
// RQ20: power-on logic clears prescaler 4096 cycles after power-up
// RQ21: internal reset clears prescaler and counter; vector fetch clears prescaler
// RQ22: disabled in monitor or break mode while test level present
// RQ23: watchdog never raises an interrupt request
// RQ24: watchdog keeps counting in wait mode
// RQ25: each option register has its own write lock
module wdol_top
   import wdol_pkg::*;
(
   // clock and resets
   input wire logic clock,
   input wire logic rst,
   input wire logic por,
   // cpu bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] vector_low,
   output logic [7:0] bus_rdata,
   // cpu and system status
   input wire logic stop_exec,
   input wire logic stop_wake,
   input wire logic detector_reset,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic test_level_on_reset,
   input wire logic test_level_on_irq,
   // option outputs
   output wdol_opts_s opts,
   output logic stop_illegal,
   output logic oscillator_run,
   output logic detector_enable,
   output logic timebase_tick,
   output logic recovery_done,
   // watchdog reset
   output logic reset_pin_low,
   output logic watchdog_flag
);
   // ==================================================
   // option latches
   localparam int REC_W = $clog2(WDOL_REC_LONG + 1);
   localparam logic [REC_W-1:0] REC_SHORT_N = REC_W'(WDOL_REC_SHORT - 1);
   localparam logic [REC_W-1:0] REC_LONG_N = REC_W'(WDOL_REC_LONG - 1);
   localparam logic [12:0] POR_N = 13'(WDOL_POR_CLEAR - 1);
   localparam logic [5:0] PULSE_N = 6'(WDOL_RST_PULSE - 1);
   localparam logic [6:0] TB_N = 7'(WDOL_TB_DIV - 1);

   logic [7:0] opt_two_q;
   logic [7:0] opt_one_q;
   logic lock_two_q;
   logic lock_one_q;
   logic vmode_q;
   logic vmode_lock_q;
   logic wr_two;
   logic wr_one;
   logic wr_svc;
   logic [7:0] opt_one_view;

   assign wr_two = bus_wr && bus_addr == WDOL_ADDR_OPT_TWO;
   assign wr_one = bus_wr && bus_addr == WDOL_ADDR_OPT_ONE;
   assign wr_svc = bus_wr && bus_addr == WDOL_ADDR_SERVICE;

   // separate locks so writing one register leaves the other open
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         opt_two_q <= WDOL_OPT_TWO_RST;
         lock_two_q <= 1'b0;
      end else if (wr_two && !lock_two_q) begin // [RQ1] [RQ25]
         opt_two_q <= bus_wdata;
         lock_two_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         opt_one_q <= WDOL_OPT_ONE_RST; // [RQ8]
         lock_one_q <= 1'b0;
      end else if (wr_one && !lock_one_q) begin // [RQ1] [RQ25]
         opt_one_q <= bus_wdata;
         lock_one_q <= 1'b1;
      end
   end

   // voltage mode survives ordinary resets; only power-on clears and re-arms it
   always_ff @(posedge clock or posedge por) begin
      if (por) begin
         vmode_q <= 1'b0; // [RQ3]
         vmode_lock_q <= 1'b0;
      end else if (wr_one && !vmode_lock_q) begin // [RQ3]
         vmode_q <= bus_wdata[WDOL_O1_DET_VMODE];
         vmode_lock_q <= 1'b1;
      end
   end

   always_comb begin
      opt_one_view = opt_one_q;
      opt_one_view[WDOL_O1_DET_VMODE] = vmode_q;
   end

   // ==================================================
   // read port
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         unique case (bus_addr)
            WDOL_ADDR_OPT_TWO: bus_rdata <= opt_two_q; // [RQ2]
            WDOL_ADDR_OPT_ONE: bus_rdata <= opt_one_view; // [RQ2]
            WDOL_ADDR_SERVICE: bus_rdata <= vector_low; // [RQ17]
            default: bus_rdata <= 8'h00;
         endcase
      end
   end

   // ==================================================
   // stop mode sequencing
   wdol_mode_e mode_q;
   logic [REC_W-1:0] rec_q;
   logic long_rec_q;

   // last recovery count; a detector wake forces the long delay
   function automatic logic [REC_W-1:0] rec_limit(input logic long_rec, input logic short_bit);
      return (long_rec || !short_bit) ? REC_LONG_N : REC_SHORT_N;
   endfunction

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_q <= WDOL_RUN;
         rec_q <= '0;
         long_rec_q <= 1'b0;
      end else begin
         unique case (mode_q)
            WDOL_RUN: begin
               if (stop_exec && opt_one_q[WDOL_O1_STOP_EN]) begin // [RQ13]
                  mode_q <= WDOL_STOP;
               end
            end
            WDOL_STOP: begin
               if (stop_wake || detector_reset) begin
                  mode_q <= WDOL_RECOVER;
                  long_rec_q <= detector_reset; // [RQ12]
                  rec_q <= '0;
               end
            end
            WDOL_RECOVER: begin
               rec_q <= rec_q + 1'b1;
               if (rec_q == rec_limit(long_rec_q, opt_one_q[WDOL_O1_SHORT_REC])) begin // [RQ11] [RQ12]
                  mode_q <= WDOL_RUN;
               end
            end
            default: mode_q <= WDOL_RUN;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         recovery_done <= 1'b0;
      end else begin
         recovery_done <= mode_q == WDOL_RECOVER &&
            rec_q == rec_limit(long_rec_q, opt_one_q[WDOL_O1_SHORT_REC]);
      end
   end

   // ==================================================
   // option-driven outputs
   logic [6:0] tb_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tb_q <= '0;
         timebase_tick <= 1'b0;
      end else if (opt_two_q[WDOL_O2_TIMEBASE_SEL]) begin // [RQ4]
         tb_q <= (tb_q == TB_N) ? 7'h00 : tb_q + 1'b1;
         timebase_tick <= tb_q == TB_N;
      end else begin
         tb_q <= '0;
         timebase_tick <= 1'b1; // [RQ4]
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         opts <= '0;
         stop_illegal <= 1'b0;
         oscillator_run <= 1'b1;
         detector_enable <= 1'b0;
      end else begin
         opts.timebase_prescale_select <= opt_two_q[WDOL_O2_TIMEBASE_SEL];
         opts.oscillator_in_stop_enable <= opt_two_q[WDOL_O2_OSC_IN_STOP];
         opts.serial_baud_clock_source <= opt_two_q[WDOL_O2_BAUD_SRC]; // [RQ6]
         opts.detector_stop_enable <= opt_one_q[WDOL_O1_DET_STOP_EN];
         opts.detector_reset_disable <= opt_one_q[WDOL_O1_DET_RST_DIS]; // [RQ9]
         opts.detector_power_disable <= opt_one_q[WDOL_O1_DET_PWR_DIS]; // [RQ9]
         opts.detector_voltage_mode <= vmode_q; // [RQ10]
         opts.stop_instruction_enable <= opt_one_q[WDOL_O1_STOP_EN];
         stop_illegal <= stop_exec && !opt_one_q[WDOL_O1_STOP_EN]; // [RQ13]
         oscillator_run <= mode_q != WDOL_STOP ||
                           opt_two_q[WDOL_O2_OSC_IN_STOP]; // [RQ5]
         detector_enable <= !opt_one_q[WDOL_O1_DET_PWR_DIS] &&
            (mode_q != WDOL_STOP || opt_one_q[WDOL_O1_DET_STOP_EN]); // [RQ8] [RQ9]
      end
   end

   // ==================================================
   // watchdog counter; runs in wait mode, stop mode or wd_off halts its clock
   logic [WDOL_PRE_BITS-1:0] pre_q;
   logic [WDOL_CNT_BITS-1:0] cnt_q;
   logic [12:0] por_q;
   logic por_clear;
   logic vec_fetch;
   logic wd_off;
   logic tap;
   logic overflow;

   always_ff @(posedge clock or posedge por) begin
      if (por) begin
         por_q <= '0;
      end else if (por_q != 13'h1FFF && por_q <= POR_N) begin
         por_q <= por_q + 1'b1;
      end
   end
   assign por_clear = por_q == POR_N; // [RQ20]

   assign vec_fetch = bus_rd && (bus_addr == WDOL_ADDR_VEC_HI); // [RQ21]
   assign wd_off = opt_one_q[WDOL_O1_WDOG_DIS] || // [RQ14]
      (monitor_mode && (test_level_on_reset || test_level_on_irq)) ||
      (break_state && test_level_on_reset); // [RQ22]
   // counter steps every 128 or 4096 cycles; a service keeps the low four stages,
   // so 64 steps less up to 16 cycles give 8176 or 262128
   assign tap = opt_one_q[WDOL_O1_RATE_SEL] ? // [RQ7]
      (pre_q[6:0] == 7'h7F) :
      (pre_q == 12'hFFF);
   assign overflow = tap && cnt_q == 6'h3F && !wd_off &&
      mode_q != WDOL_STOP; // [RQ15] [RQ24]

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_q <= '0; // [RQ21]
         cnt_q <= '0;
      end else if (stop_exec || vec_fetch || por_clear) begin // [RQ19] [RQ20] [RQ21]
         pre_q <= '0;
         if (wr_svc) begin
            cnt_q <= '0;
         end
      end else if (wr_svc) begin // [RQ16]
         cnt_q <= '0;
         pre_q <= {8'h00, pre_q[3:0]};
      end else if (mode_q != WDOL_STOP && !wd_off) begin // [RQ24]
         pre_q <= pre_q + 1'b1; // [RQ15]
         if (tap) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // ==================================================
   // reset pulse; no interrupt output exists by design [RQ23]
   logic [5:0] pulse_q;
   logic pulsing_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pulse_q <= '0;
         pulsing_q <= 1'b0;
         reset_pin_low <= 1'b0;
      end else if (overflow) begin
         pulsing_q <= 1'b1;
         pulse_q <= '0;
         reset_pin_low <= 1'b1; // [RQ18]
      end else if (pulsing_q) begin
         pulse_q <= pulse_q + 1'b1;
         if (pulse_q == PULSE_N) begin // [RQ18]
            pulsing_q <= 1'b0;
            reset_pin_low <= 1'b0;
         end
      end
   end

   // flag survives the chip reset it causes; cleared by power-on only
   always_ff @(posedge clock or posedge por) begin
      if (por) begin
         watchdog_flag <= 1'b0;
      end else if (overflow) begin
         watchdog_flag <= 1'b1; // [RQ18]
      end
   end
endmodule

// ### verif/wdol_asserts.sv
// checker on the ports of wdol_top
// assumes one clock domain; bound to every wdol_top instance
module wdol_asserts
   import wdol_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_rd,
   input wire logic [7:0] vector_low,
   input wire logic [7:0] bus_rdata,
   // status and options
   input wire logic stop_exec,
   input wire wdol_opts_s opts,
   input wire logic stop_illegal,
   input wire logic oscillator_run,
   input wire logic detector_enable,
   input wire logic timebase_tick,
   input wire logic reset_pin_low,
   input wire logic watchdog_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ==================================================
   // length of the reset pin pulse
   logic [5:0] low_q;
   always_ff @(posedge clock or posedge rst)
      if (rst) low_q <= 6'h00;
      else low_q <= reset_pin_low ? low_q + 6'h01 : 6'h00;
   sequence s_vec_read;
      bus_rd && bus_addr == WDOL_ADDR_SERVICE;
   endsequence
   // ==================================================
   AST_VEC_READ: assert property (s_vec_read |=> bus_rdata == $past(vector_low))
      else $error("service read data wrong");
   AST_STOP_ILL: assert property (stop_exec && !opts.stop_instruction_enable |=> stop_illegal)
      else $error("stop not refused");
   AST_STOP_OK: assert property (stop_exec && opts.stop_instruction_enable |=> !stop_illegal)
      else $error("legal stop refused");
   AST_PIN_LEN: assert property ($fell(reset_pin_low) |-> low_q == 6'h20)
      else $error("reset pin pulse length wrong");
   AST_PIN_MAX: assert property (low_q <= 6'h20)
      else $error("reset pin held too long");
   AST_FLAG: assert property ($rose(reset_pin_low) |-> ##[0:2] watchdog_flag)
      else $error("watchdog flag not set");
   AST_TB_BYP: assert property (!opts.timebase_prescale_select [*3] |-> timebase_tick)
      else $error("timebase tick missing");
   AST_OSC: assert property (opts.oscillator_in_stop_enable
      && $past(opts.oscillator_in_stop_enable) |-> oscillator_run)
      else $error("oscillator stopped");
   AST_DET: assert property (opts.detector_power_disable
      && $past(opts.detector_power_disable) |-> !detector_enable)
      else $error("detector powered");
endmodule
bind wdol_top wdol_asserts u_wdol_asserts (.clock(clock), .rst(rst), .bus_addr(bus_addr),
   .bus_rd(bus_rd), .vector_low(vector_low), .bus_rdata(bus_rdata), .stop_exec(stop_exec),
   .opts(opts), .stop_illegal(stop_illegal), .oscillator_run(oscillator_run),
   .detector_enable(detector_enable), .timebase_tick(timebase_tick),
   .reset_pin_low(reset_pin_low), .watchdog_flag(watchdog_flag));

// ### verif/wdol_cpu_model.sv
// cpu core model: master of the internal bus
// assumes single-cycle strobes launched just after a rising edge
module wdol_cpu_model (
   // clock
   input wire logic clock,
   // cpu bus
   output logic [15:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bus_addr = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end
   task automatic bw(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
      // stale data would hide a strobe that is ignored
      bus_wdata <= ~d;
   endtask
   task automatic br(input logic [15:0] a);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
   endtask
endmodule

// ### verif/wdol_top_test.sv
// self-checking bench for wdol_top
// assumes the cpu model drives the bus and reads are checked from a queue
module wdol_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import wdol_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic por = 1'b1;
   logic [15:0] bus_addr;
   logic bus_wr, bus_rd, stop_illegal, oscillator_run, detector_enable;
   logic timebase_tick, recovery_done, reset_pin_low, watchdog_flag;
   logic [7:0] bus_wdata, bus_rdata;
   logic [7:0] vector_low = 8'h00;
   logic stop_exec = 1'b0, stop_wake = 1'b0, det_rst = 1'b0, monitor_mode = 1'b0;
   logic break_state = 1'b0, tl_rst = 1'b0, tl_irq = 1'b0, rd_seen = 1'b0;
   wdol_opts_s opts;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hE654C186;
   int fails = 0;
   int n_tests = 0;
   always #25 clock = ~clock;
   wdol_cpu_model u_wdol_cpu_model (.clock(clock), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata));
   wdol_top u_wdol_top (.clock(clock), .rst(rst), .por(por), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .vector_low(vector_low),
      .bus_rdata(bus_rdata), .stop_exec(stop_exec), .stop_wake(stop_wake),
      .detector_reset(det_rst), .monitor_mode(monitor_mode), .break_state(break_state),
      .test_level_on_reset(tl_rst), .test_level_on_irq(tl_irq), .opts(opts),
      .stop_illegal(stop_illegal), .oscillator_run(oscillator_run),
      .detector_enable(detector_enable), .timebase_tick(timebase_tick),
      .recovery_done(recovery_done), .reset_pin_low(reset_pin_low),
      .watchdog_flag(watchdog_flag));
   // ==================================================
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_wdol_cpu_model.br(a);
   endtask
   task automatic do_rst(input logic p);
      @(posedge clock);
      rst <= 1'b1;
      por <= p;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      por <= 1'b0;
   endtask
   // counts settled cycles until the reset pin fires, at most lim
   task automatic run(input int lim, output int n);
      n = 0;
      while (reset_pin_low !== 1'b1 && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask
   // stop, then wake after 8 cycles by a wake event or a detector reset
   task automatic recov(input logic lvd, output int n);
      @(posedge clock) stop_exec <= 1'b1;
      @(posedge clock) stop_exec <= 1'b0;
      repeat (8) @(posedge clock);
      stop_wake <= !lvd;
      det_rst <= lvd;
      @(posedge clock);
      stop_wake <= 1'b0;
      det_rst <= 1'b0;
      n = 0;
      while (recovery_done !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
   endtask
   // ==================================================
   always @(posedge clock) rd_seen <= bus_rd;
   always @(negedge clock)
      if (rd_seen) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, bus_rdata});
   initial begin
      #(70000 * 50);
      fails++;
      give_verdict();
   end
   initial begin
      int n;
      logic [7:0] d1, d2;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      por <= 1'b0;
      vector_low <= rnd();
      // voltage mode set so a plain reset can show that it is kept
      d2 = rnd() | 8'h08;
      d1 = rnd();
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, d2);
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, ~d2);
      rd(WDOL_ADDR_OPT_ONE, d2);
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_TWO, d1);
      rd(WDOL_ADDR_OPT_TWO, d1);
      rd(WDOL_ADDR_SERVICE, vector_low);
      @(negedge clock);
      chk("opts", {8'h00, d1[3], d1[1:0], d2[6:3], d2[1]}, {8'h00, opts});
      do_rst(1'b0);
      rd(WDOL_ADDR_OPT_ONE, 8'h08);
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, 8'hF7);
      rd(WDOL_ADDR_OPT_ONE, 8'hFF);
      @(negedge clock);
      chk("opts", 16'h001F, {8'h00, opts});
      recov(1'b0, n);
      chk("short recovery", 16'h0001, {15'h0000, n >= 30 && n <= 36});
      recov(1'b1, n);
      chk("long recovery", 16'h0001, {15'h0000, n >= 4094 && n <= 4100});
      do_rst(1'b0);
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, 8'h80);
      u_wdol_cpu_model.bw(WDOL_ADDR_SERVICE, rnd());
      repeat (6000) @(posedge clock);
      u_wdol_cpu_model.bw(WDOL_ADDR_SERVICE, rnd());
      run(9000, n);
      chk("fast period", 16'h0001, {15'h0000, n >= 8150 && n <= 8200});
      chk("flag", 16'h0001, {15'h0000, watchdog_flag});
      do_rst(1'b0);
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, 8'h81);
      @(posedge clock) stop_exec <= 1'b1;
      @(posedge clock) stop_exec <= 1'b0;
      run(9000, n);
      chk("disabled", 16'd9000, n[15:0]);
      do_rst(1'b0);
      monitor_mode <= 1'b1;
      tl_irq <= 1'b1;
      u_wdol_cpu_model.bw(WDOL_ADDR_OPT_ONE, 8'h80);
      run(9000, n);
      chk("monitor", 16'd9000, n[15:0]);
      @(posedge clock);
      monitor_mode <= 1'b0;
      tl_irq <= 1'b0;
      break_state <= 1'b1;
      tl_rst <= 1'b1;
      run(9000, n);
      chk("break", 16'd9000, n[15:0]);
      give_verdict();
   end
endmodule
